// *** common/rxqwm_map.svh ***
/*
  Register offsets, field positions and reset values of the receive-queue
  watermark and frame-tally block. Assumes byte addressing on the host bus.
*/
`ifndef RXQWM_MAP_SVH
`define RXQWM_MAP_SVH
`define RXQWM_LOW_OFS        12'h01B0
`define RXQWM_HIGH_OFS       12'h01B2
`define RXQWM_OVR_OFS        12'h01B4
`define RXQWM_TALLY_OFS      12'h01B8
`define RXQWM_LOW_RST        12'h0600
`define RXQWM_HIGH_RST       12'h0400
`define RXQWM_OVR_RST        12'h0040
`define RXQWM_TALLY_LSB      8
`define RXQWM_TALLY_MSB      15
`define RXQWM_RX_IRQ_BIT     13
`endif

// *** common/rxqwm_pkg.sv ***
/*
  Types for the receive-queue watermark block. Shared by design and bench.
*/
package rxqwm_pkg;
  typedef logic [11:0] rxqwm_dw_t;
  typedef struct packed
  {
    logic low;
    logic high;
    logic overrun;
  } rxqwm_fc_s;
endpackage

// *** verilog/rxqwm_regs.sv ***
/*
  Receive-queue watermark thresholds and received-frame tally registers.
  Assumes a synchronous 16-bit host register port with one-cycle read and
  write strobes, and a queue manager that supplies free space and frame count.
  A tally width other than 8 changes the tally register layout.
*/
`timescale 1ns/1ns
`include "rxqwm_map.svh"
// What this block does
// - a 12-bit read-write high threshold in double words resets to 0x400.
// - a 12-bit read-write overrun threshold in double words resets to 0x040.
// - bits 15 to 8 of the tally register report received frames held in the buffer.
// - the tally refreshes when the host writes one to a set receive interrupt bit 13.
// - a 12-bit read-write low threshold in double words resets to 0x600.
module rxqwm_regs
  import rxqwm_pkg::*;
#(
  parameter int TALLY_W = 8
)
(
  input  wire logic               clk_i,          // 100 MHz clock
  input  wire logic               resetn_i,       // async reset, active low
  input  wire logic               ce_i,           // clock enable, freezes state
  input  wire logic [11:0]        addr_i,         // byte address
  input  wire logic               wr_i,           // write strobe
  input  wire logic               rd_i,           // read strobe
  input  wire logic [15:0]        wdata_i,        // write data
  output logic      [15:0]        rdata_o,        // registered read data
  input  wire logic               rx_irq_set_i,   // current state of status bit 13
  input  wire logic               isr_wr_i,       // host write to status register
  input  wire logic [15:0]        isr_wdata_i,    // data of that write
  input  wire logic [TALLY_W-1:0] frames_held_i,  // live frame count in buffer
  input  wire rxqwm_dw_t          free_dw_i,      // free space in double words
  output rxqwm_fc_s               fc_o            // registered flow-control flags
);

  ////////////////////////////////////////////////////////////////////////
  rxqwm_dw_t          low_thr;
  rxqwm_dw_t          high_thr;
  rxqwm_dw_t          ovr_thr;
  logic [TALLY_W-1:0] tally;
  logic [7:0]         tally_spare;

  wire logic hit_low   = addr_i == `RXQWM_LOW_OFS;
  wire logic hit_high  = addr_i == `RXQWM_HIGH_OFS;
  wire logic hit_ovr   = addr_i == `RXQWM_OVR_OFS;
  wire logic hit_tally = addr_i == `RXQWM_TALLY_OFS;
  // refresh only when the interrupt is pending and being acknowledged
  wire logic refresh   = rx_irq_set_i && isr_wr_i && isr_wdata_i[`RXQWM_RX_IRQ_BIT];
  rxqwm_fc_s next_fc;
  logic [15:0] next_rdata;

  // equal counts as a hit so the flag is up the moment the mark is reached
  function automatic logic at_or_below(input rxqwm_dw_t space, input rxqwm_dw_t mark);
    at_or_below = space <= mark;
  endfunction

  assign next_fc.low     = at_or_below(free_dw_i, low_thr);
  assign next_fc.high    = at_or_below(free_dw_i, high_thr);
  assign next_fc.overrun = at_or_below(free_dw_i, ovr_thr);

  // reserved threshold bits read as zero
  wire logic [15:0] low_word   = {4'h0, low_thr};
  wire logic [15:0] high_word  = {4'h0, high_thr};
  wire logic [15:0] ovr_word   = {4'h0, ovr_thr};
  wire logic [15:0] tally_word = {tally, tally_spare};
  assign next_rdata = hit_low   ? low_word :
                      hit_high  ? high_word :
                      hit_ovr   ? ovr_word :
                      hit_tally ? tally_word : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      low_thr     <= `RXQWM_LOW_RST;
      high_thr    <= `RXQWM_HIGH_RST;
      ovr_thr     <= `RXQWM_OVR_RST;
      tally       <= '0;
      tally_spare <= 8'h00;
      fc_o        <= '0;
      rdata_o     <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (wr_i && hit_low)   low_thr  <= wdata_i[11:0];
      if (wr_i && hit_high)  high_thr <= wdata_i[11:0];
      if (wr_i && hit_ovr)   ovr_thr  <= wdata_i[11:0];
      if (wr_i && hit_tally) tally_spare <= wdata_i[7:0];
      // snapshot so the host sees a stable count while draining headers
      if (refresh)           tally <= frames_held_i;
      fc_o <= next_fc;
      if (rd_i)              rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_high_reset;
    @(posedge clk_i) $rose(resetn_i) |-> high_thr == `RXQWM_HIGH_RST;
  endproperty
  a_high_reset: assert property (p_high_reset) else $error("high threshold reset wrong");

  property p_ovr_reset;
    @(posedge clk_i) $rose(resetn_i) |-> ovr_thr == `RXQWM_OVR_RST;
  endproperty
  a_ovr_reset: assert property (p_ovr_reset) else $error("overrun threshold reset wrong");

  property p_low_reset;
    @(posedge clk_i) $rose(resetn_i) |-> low_thr == `RXQWM_LOW_RST;
  endproperty
  a_low_reset: assert property (p_low_reset) else $error("low threshold reset wrong");

  property p_high_write;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && wr_i && hit_high |=> high_thr == $past(wdata_i[11:0]);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high threshold not written");

  property p_tally_read;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && rd_i && hit_tally |=> rdata_o[15:8] == $past(tally);
  endproperty
  a_tally_read: assert property (p_tally_read) else $error("tally read wrong");

  property p_refresh;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && refresh |=> tally == $past(frames_held_i);
  endproperty
  a_refresh: assert property (p_refresh) else $error("tally not refreshed");

  property p_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      !refresh |=> $stable(tally);
  endproperty
  a_hold: assert property (p_hold) else $error("tally changed without ack");

  property p_overrun_flag;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> fc_o.overrun == ($past(free_dw_i) <= $past(ovr_thr));
  endproperty
  a_overrun_flag: assert property (p_overrun_flag) else $error("overrun flag wrong");

  property p_high_flag;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> fc_o.high == ($past(free_dw_i) <= $past(high_thr));
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag wrong");

  property p_low_flag;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> fc_o.low == ($past(free_dw_i) <= $past(low_thr));
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag wrong");

  // remaining write paths
  property p_ovr_write;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && wr_i && hit_ovr |=> ovr_thr == $past(wdata_i[11:0]);
  endproperty
  a_ovr_write: assert property (p_ovr_write) else $error("overrun threshold not written");

  property p_low_write;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && wr_i && hit_low |=> low_thr == $past(wdata_i[11:0]);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low threshold not written");

  property p_spare_write;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && wr_i && hit_tally |=> tally_spare == $past(wdata_i[7:0]);
  endproperty
  a_spare_write: assert property (p_spare_write) else $error("tally spare byte not written");

  // read-back framing and refused acknowledges
  property p_thr_read;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && rd_i && (hit_low || hit_high || hit_ovr) |=> rdata_o[15:12] == 4'h0;
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("threshold upper bits not zero");

  property p_refresh_refused;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && isr_wr_i && !rx_irq_set_i |=> $stable(tally);
  endproperty
  a_refresh_refused: assert property (p_refresh_refused) else $error("tally moved on refused ack");

  // values right after reset release
  property p_tally_reset;
    @(posedge clk_i) $rose(resetn_i) |-> tally == '0;
  endproperty
  a_tally_reset: assert property (p_tally_reset) else $error("tally reset wrong");

  property p_fc_reset;
    @(posedge clk_i) $rose(resetn_i) |-> fc_o == '0;
  endproperty
  a_fc_reset: assert property (p_fc_reset) else $error("flow flags reset wrong");

  // a low enable must freeze every register, read data included; tally_spare is left out of this check
  property p_freeze;
    @(posedge clk_i) disable iff (!resetn_i)
      !ce_i |=> $stable(low_thr) && $stable(high_thr) && $stable(ovr_thr) && $stable(tally)
                && $stable(rdata_o) && $stable(fc_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !rd_i |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  ////////////////////////////////////////////////////////////////////////
  // main scenarios seen at least once
  c_refresh:  cover property (@(posedge clk_i) disable iff (!resetn_i) ce_i && refresh);
  c_low_only: cover property (@(posedge clk_i) disable iff (!resetn_i) fc_o.low && !fc_o.high);
  c_frozen:   cover property (@(posedge clk_i) disable iff (!resetn_i) !ce_i && wr_i);
  c_overrun:  cover property (@(posedge clk_i) disable iff (!resetn_i) fc_o.overrun);
  c_rd_tally: cover property (@(posedge clk_i) disable iff (!resetn_i) ce_i && rd_i && hit_tally);
endmodule

// *** test/rxqwm_qm_model.sv ***
/* queue manager stand-in: frame count and free space.
   assumes the bench sets targets; outputs move on the falling edge. */
`timescale 1ns/1ns
module rxqwm_qm_model
  import rxqwm_pkg::*;
(
  input  wire logic       clk_i,   // bench clock
  input  wire logic [7:0] frm_i,   // wanted frame count
  input  wire rxqwm_dw_t  free_i,  // wanted free space
  output logic      [7:0] frm_o,   // frames held
  output rxqwm_dw_t       free_o   // free double words
);
  always @(negedge clk_i)
  begin
    frm_o  <= frm_i;
    free_o <= free_i;
  end
endmodule

// *** test/tb.sv ***
/* register bench: reset values, write/read, tally refresh, flow flags.
   assumes one-cycle strobes; ce_i driven by the scenarios. */
`timescale 1ns/1ns
`include "rxqwm_map.svh"
module tb;
  import rxqwm_pkg::*;
  logic        clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, irq = 0, isr_wr = 0, ce = 1;
  logic [11:0] addr_i = '0;
  logic [15:0] wdata_i = '0, isr_d = '0, rdata_o;
  logic [7:0]  frm = '0, frm_q;
  rxqwm_dw_t   free = '0, free_q;
  rxqwm_fc_s   fc_o;
  int          mismatches = 0, samples_checked = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  rxqwm_qm_model qm (.clk_i, .frm_i(frm), .free_i(free), .frm_o(frm_q), .free_o(free_q));
  rxqwm_regs uut (.clk_i, .resetn_i, .ce_i(ce), .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .rx_irq_set_i(irq), .isr_wr_i(isr_wr), .isr_wdata_i(isr_d), .frames_held_i(frm_q),
    .free_dw_i(free_q), .fc_o);
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(negedge clk_i);
    {addr_i, wr_i, rd_i, wdata_i} = {a, w, !w, d};
    @(negedge clk_i);
    {wr_i, rd_i} = 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    acc(0, a, 16'h0000);
    cmp(rdata_o, e);
  endtask
  task automatic ack(input logic [15:0] d);
    @(negedge clk_i);
    {isr_wr, isr_d} = {1'b1, d};
    @(negedge clk_i);
    isr_wr = 0;
  endtask
  task automatic t_reset();
    rd(`RXQWM_LOW_OFS, 16'h0600);
    rd(`RXQWM_HIGH_OFS, 16'h0400);
    rd(`RXQWM_OVR_OFS, 16'h0040);
    rd(`RXQWM_TALLY_OFS, 16'h0000);
    rd(12'h1BA, 16'h0000);
  endtask
  task automatic t_fc();
    logic [11:0] fr [6] = '{12'h601, 12'h600, 12'h401, 12'h400, 12'h041, 12'h040};
    logic [2:0]  ex [6] = '{3'b000, 3'b100, 3'b100, 3'b110, 3'b110, 3'b111};
    foreach (fr[i])
    begin
      free = fr[i];
      repeat (3) @(negedge clk_i);
      cmp(16'(fc_o), 16'(ex[i]));
    end
  endtask
  task automatic t_tally();
    frm = 8'h05;
    ack(16'h2000);
    rd(`RXQWM_TALLY_OFS, 16'h0000);
    irq = 1;
    ack(16'hDFFF);
    rd(`RXQWM_TALLY_OFS, 16'h0000);
    ack(16'h2000);
    irq = 0;
    frm = 8'h07;
    rd(`RXQWM_TALLY_OFS, 16'h0500);
    acc(1, `RXQWM_TALLY_OFS, 16'hFFA5);
    rd(`RXQWM_TALLY_OFS, 16'h05A5);
  endtask
  task automatic t_rw();
    acc(1, `RXQWM_HIGH_OFS, 16'hF123);
    acc(1, `RXQWM_OVR_OFS, 16'h0FFF);
    acc(1, `RXQWM_LOW_OFS, 16'h0ABC);
    rd(`RXQWM_HIGH_OFS, 16'h0123);
    rd(`RXQWM_OVR_OFS, 16'h0FFF);
    rd(`RXQWM_LOW_OFS, 16'h0ABC);
    free = 12'hABD;
    repeat (3) @(negedge clk_i);
    cmp(16'(fc_o), 16'h0001);
  endtask
  task automatic t_ce();
    ce = 0;
    acc(1, `RXQWM_HIGH_OFS, 16'h0777);
    rd(`RXQWM_LOW_OFS, 16'h0ABC);
    ce = 1;
    rd(`RXQWM_HIGH_OFS, 16'h0123);
  endtask
  task automatic t_rst2();
    @(negedge clk_i);
    resetn_i = 0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1;
    t_reset();
  endtask
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    repeat (5) @(negedge clk_i);
    resetn_i = 1;
    t_reset();
    t_fc();
    t_tally();
    t_rw();
    t_ce();
    t_rst2();
    finish_test();
  end
endmodule
